// >>> hw/smsp_pkg.sv
// package: constants and carrier types of the serial master/slave port
package smsp_pkg;

   // ------------------------------------------------------------
   // control bit layout (positions inside the control byte)
   // ------------------------------------------------------------
   localparam int CTL_IRQ_EN = 7;
   localparam int CTL_ENABLE = 6;
   localparam int CTL_LSB_FIRST = 5;
   localparam int CTL_MASTER = 4;
   localparam int CTL_CPOL = 3;
   localparam int CTL_CPHA = 2;
   localparam int CTL_RATE_HI = 1;
   localparam int CTL_RATE_LO = 0;
   localparam logic [7:0] CTL_RESET = 8'h00;
   localparam logic [7:0] DATA_RESET = 8'h00;

   // ------------------------------------------------------------
   // timing: sck half period in clk cycles, indexed {2x,hi,lo}
   // ------------------------------------------------------------
   localparam int HALF_W = 6;
   localparam int BITS_PER_BYTE = 8;
   localparam logic [3:0] LAST_EDGE = 4'hf;
   localparam logic [HALF_W-1:0] HALF_DIV4 = 6'h02;
   localparam logic [HALF_W-1:0] HALF_DIV16 = 6'h08;
   localparam logic [HALF_W-1:0] HALF_DIV64 = 6'h20;
   localparam logic [HALF_W-1:0] HALF_DIV128 = 6'h3f;
   localparam logic [HALF_W-1:0] HALF_DIV2 = 6'h01;
   localparam logic [HALF_W-1:0] HALF_DIV8 = 6'h04;
   localparam logic [HALF_W-1:0] HALF_DIV32 = 6'h10;
   localparam int BUF_DEPTH = 2;

   // controls as seen by the shifting logic
   typedef struct packed {
      logic irq_en;
      logic enable;
      logic lsb_first;
      logic master;
      logic cpol;
      logic cpha;
      logic rate_hi;
      logic rate_lo;
   } smsp_ctl_t;

   typedef enum logic [1:0] {
      SMSP_IDLE,
      SMSP_MRUN,
      SMSP_SRUN
   } smsp_mode_t;

endpackage

// >>> hw/smsp_port.sv
// serial master/slave byte port: shifter, clock generator, buffers
`timescale 1ns/1ns
`default_nettype none

module smsp_port (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic serial_power_reduction_bit_i,
   input wire logic ctl_write_i,
   input wire logic [7:0] serial_control_register_i,
   input wire logic double_speed_bit_i,
   input wire logic data_write_i,
   input wire logic [7:0] shift_data_register_i,
   input wire logic data_read_i,
   input wire logic flag_clear_i,
   input wire logic select_is_input_i,
   input wire logic miso_user_oe_i,
   input wire logic mosi_user_oe_i,
   input wire logic sck_user_oe_i,
   input wire logic sck_i,
   input wire logic mosi_i,
   input wire logic miso_i,
   input wire logic select_n_i,
   output logic [7:0] serial_control_register_o,
   output logic [7:0] shift_data_register_o,
   output logic rx_valid_o,
   output logic transfer_done_flag_o,
   output logic irq_o,
   output logic busy_o,
   output logic sck_o,
   output logic sck_oe_o,
   output logic mosi_o,
   output logic mosi_oe_o,
   output logic miso_o,
   output logic miso_oe_o
);

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   typedef struct packed {
      smsp_pkg::smsp_ctl_t ctl;
      smsp_pkg::smsp_mode_t mode;
      logic [7:0] shreg;
      logic [3:0] edges;
      logic [smsp_pkg::HALF_W-1:0] div;
      logic sck_lvl;
      logic out_bit;
      logic done;
      logic rx_push;
      logic [7:0] rx_byte;
      logic [2:0] sck_s;
      logic [1:0] mosi_s;
      logic [1:0] miso_s;
      logic [2:0] sel_s;
      logic irq;
      logic [7:0] rd_data;
      logic rd_valid;
      logic sck_out;
      logic sck_oe;
      logic mosi_out;
      logic mosi_oe;
      logic miso_out;
      logic miso_oe;
      logic busy;
   } smsp_st_t;

   smsp_st_t st;
   smsp_st_t next_st;
   logic buf_in_ready;
   logic buf_out_valid;
   logic [7:0] buf_out_data;
   logic buf_pop;

   // half period select for the master clock generator
   function automatic logic [smsp_pkg::HALF_W-1:0] half_period(
      input logic dbl, input logic hi, input logic lo);
      unique case ({dbl, hi, lo})
         3'h0: half_period = smsp_pkg::HALF_DIV4;
         3'h1: half_period = smsp_pkg::HALF_DIV16;
         3'h2: half_period = smsp_pkg::HALF_DIV64;
         3'h3: half_period = smsp_pkg::HALF_DIV128;
         3'h4: half_period = smsp_pkg::HALF_DIV2;
         3'h5: half_period = smsp_pkg::HALF_DIV8;
         3'h6: half_period = smsp_pkg::HALF_DIV32;
         3'h7: half_period = smsp_pkg::HALF_DIV64;
      endcase
   endfunction

   // bit presented on the data line for a given shift register value
   function automatic logic tx_bit(input logic [7:0] sr, input logic lsb);
      tx_bit = lsb ? sr[0] : sr[7];
   endfunction

   // shift one sampled bit into the register in the chosen order
   function automatic logic [7:0] shift_in(
      input logic [7:0] sr, input logic lsb, input logic b);
      shift_in = lsb ? {b, sr[7:1]} : {sr[6:0], b};
   endfunction

   // ------------------------------------------------------------
   // receive buffer: protects an unread byte while the next shifts
   // ------------------------------------------------------------
   assign buf_pop = data_read_i;

   smsp_rx_buf u_rx_buf (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .in_valid_i(st.rx_push),
      .in_data_i(st.rx_byte),
      .in_ready_o(buf_in_ready),
      .out_valid_o(buf_out_valid),
      .out_data_o(buf_out_data),
      .out_ready_i(buf_pop)
   );

   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   always_comb begin
      logic active;
      logic lsb;
      logic sel_low;
      logic sck_rise;
      logic sck_fall;
      logic lead;
      logic sample;
      logic setup;
      logic in_bit;
      lead = 1'b0;
      sample = 1'b0;
      setup = 1'b0;
      in_bit = 1'b0;
      next_st = st;
      active = st.ctl.enable && !serial_power_reduction_bit_i;
      lsb = st.ctl.lsb_first;
      next_st.rx_push = 1'b0;
      // pins from outside pass two flip-flops first
      next_st.sck_s = {st.sck_s[1:0], sck_i};
      next_st.mosi_s = {st.mosi_s[0], mosi_i};
      next_st.miso_s = {st.miso_s[0], miso_i};
      next_st.sel_s = {st.sel_s[1:0], select_n_i};
      sel_low = !st.sel_s[1];
      sck_rise = st.sck_s[1] && !st.sck_s[2];
      sck_fall = !st.sck_s[1] && st.sck_s[2];
      if (ctl_write_i) begin
         next_st.ctl = smsp_pkg::smsp_ctl_t'(serial_control_register_i);
      end
      if (flag_clear_i) begin
         next_st.done = 1'b0;
      end
      if (!active) begin
         next_st.mode = smsp_pkg::SMSP_IDLE;
         next_st.sck_lvl = st.ctl.cpol;
      end else if (st.ctl.master && select_is_input_i && sel_low) begin
         // another master selected us: give up the bus
         next_st.ctl.master = 1'b0;
         next_st.mode = smsp_pkg::SMSP_IDLE;
         next_st.done = 1'b1;
         next_st.sck_lvl = st.ctl.cpol;
      end else begin
         unique case (st.mode)
            smsp_pkg::SMSP_IDLE: begin
               next_st.sck_lvl = st.ctl.cpol;
               // writes while shifting are ignored: single buffered
               if (data_write_i) begin
                  next_st.shreg = shift_data_register_i;
                  next_st.out_bit = tx_bit(shift_data_register_i, lsb);
               end
               next_st.edges = 4'h0;
               next_st.div = half_period(double_speed_bit_i,
                  st.ctl.rate_hi, st.ctl.rate_lo);
               if (st.ctl.master && data_write_i) begin
                  next_st.mode = smsp_pkg::SMSP_MRUN;
               end else if (!st.ctl.master && sel_low) begin
                  next_st.mode = smsp_pkg::SMSP_SRUN;
               end
            end
            smsp_pkg::SMSP_MRUN: begin
               if (st.div == 6'h01) begin
                  next_st.div = half_period(double_speed_bit_i,
                     st.ctl.rate_hi, st.ctl.rate_lo);
                  next_st.sck_lvl = ~st.sck_lvl;
                  next_st.edges = st.edges + 4'h1;
                  lead = !st.edges[0];
                  sample = (lead != st.ctl.cpha);
                  if (sample) begin
                     next_st.shreg = shift_in(st.shreg, lsb,
                        st.miso_s[1]);
                  end else if (st.edges != 4'h0 || !st.ctl.cpha) begin
                     next_st.out_bit = tx_bit(st.shreg, lsb);
                  end
                  if (st.edges == smsp_pkg::LAST_EDGE) begin
                     next_st.mode = smsp_pkg::SMSP_IDLE;
                     next_st.done = 1'b1;
                     next_st.rx_byte = next_st.shreg;
                     next_st.rx_push = 1'b1;
                  end
               end else begin
                  next_st.div = st.div - 6'h01;
               end
            end
            smsp_pkg::SMSP_SRUN: begin
               if (!sel_low || st.ctl.master) begin
                  // deselect drops a partial byte and rearms
                  next_st.mode = smsp_pkg::SMSP_IDLE;
                  next_st.edges = 4'h0;
               end else if (sck_rise || sck_fall) begin
                  // relies on sck phases longer than two cycles
                  lead = (st.ctl.cpol ? sck_fall : sck_rise);
                  sample = (lead != st.ctl.cpha);
                  setup = !sample;
                  in_bit = st.mosi_s[1];
                  next_st.edges = st.edges + 4'h1;
                  if (sample) begin
                     next_st.shreg = shift_in(st.shreg, lsb, in_bit);
                  end else if (setup && (st.edges != 4'h0)) begin
                     next_st.out_bit = tx_bit(st.shreg, lsb);
                  end
                  if (st.edges == smsp_pkg::LAST_EDGE) begin
                     next_st.done = 1'b1;
                     next_st.rx_byte = next_st.shreg;
                     next_st.rx_push = 1'b1;
                     next_st.edges = 4'h0;
                  end
               end
               if (data_write_i && st.edges == 4'h0) begin
                  next_st.shreg = shift_data_register_i;
                  next_st.out_bit = tx_bit(shift_data_register_i, lsb);
               end
            end
            default: next_st.mode = smsp_pkg::SMSP_IDLE;
         endcase
      end
      next_st.busy = (next_st.mode != smsp_pkg::SMSP_IDLE);
      // receive: a full buffer refuses the newest byte on overrun
      if (buf_out_valid) begin
         next_st.rd_data = buf_out_data;
      end
      next_st.rd_valid = buf_out_valid;
      // set wins over a clear in the same cycle
      if (next_st.rx_push) begin
         next_st.done = 1'b1;
      end
      next_st.irq = next_st.done && next_st.ctl.irq_en;
      // pin direction overrides; select is never driven
      next_st.sck_out = st.sck_lvl;
      next_st.mosi_out = st.out_bit;
      next_st.miso_out = st.out_bit;
      if (active && st.ctl.master) begin
         next_st.miso_oe = 1'b0;
         next_st.mosi_oe = mosi_user_oe_i;
         next_st.sck_oe = sck_user_oe_i;
      end else if (active) begin
         next_st.mosi_oe = 1'b0;
         next_st.sck_oe = 1'b0;
         next_st.miso_oe = miso_user_oe_i && sel_low;
      end else begin
         next_st.mosi_oe = 1'b0;
         next_st.sck_oe = 1'b0;
         next_st.miso_oe = 1'b0;
      end
   end

   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         st <= '0;
         st.sel_s <= 3'h7;
      end else begin
         st <= next_st;
      end
   end

   // a byte pushed into a full buffer is refused; reading frees room
   logic unused_ready;
   assign unused_ready = buf_in_ready;

   assign serial_control_register_o = st.ctl;
   assign shift_data_register_o = st.rd_data;
   assign rx_valid_o = st.rd_valid;
   assign transfer_done_flag_o = st.done;
   assign irq_o = st.irq;
   assign busy_o = st.busy;
   assign sck_o = st.sck_out;
   assign sck_oe_o = st.sck_oe;
   assign mosi_o = st.mosi_out;
   assign mosi_oe_o = st.mosi_oe;
   assign miso_o = st.miso_out;
   assign miso_oe_o = st.miso_oe;

endmodule

`default_nettype wire

// >>> hw/smsp_rx_buf.sv
// two-entry receive buffer with valid/ready on both sides
`timescale 1ns/1ns
`default_nettype none

module smsp_rx_buf (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic in_valid_i,
   input wire logic [7:0] in_data_i,
   output logic in_ready_o,
   output logic out_valid_o,
   output logic [7:0] out_data_o,
   input wire logic out_ready_i
);

   typedef struct packed {
      logic [smsp_pkg::BUF_DEPTH-1:0][7:0] mem;
      logic [1:0] count;
      logic rd;
      logic wr;
   } smsp_buf_st_t;

   smsp_buf_st_t st;
   smsp_buf_st_t next_st;
   logic push;
   logic pop;

   assign push = in_valid_i && in_ready_o;
   assign pop = out_valid_o && out_ready_i;
   assign in_ready_o = (st.count != 2'h2);
   assign out_valid_o = (st.count != 2'h0);
   assign out_data_o = st.mem[st.rd];

   always_comb begin
      next_st = st;
      if (push) begin
         next_st.mem[st.wr] = in_data_i;
         next_st.wr = ~st.wr;
      end
      if (pop) begin
         next_st.rd = ~st.rd;
      end
      next_st.count = st.count + {1'b0, push} - {1'b0, pop};
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

endmodule

`default_nettype wire

// >>> verification/smsp_far_slave.sv
// far-side model: an external slave device on the serial bus
`timescale 1ns/1ns
`default_nettype none

module smsp_far_slave (
   input wire logic sck_i,
   input wire logic sel_n_i,
   input wire logic mosi_i,
   input wire logic cpol_i,
   input wire logic cpha_i,
   input wire logic lsb_i,
   input wire logic [7:0] tx_i,
   output logic miso_o,
   output logic [7:0] rx_o
);
   logic [7:0] sh;

   task automatic put();
      miso_o = lsb_i ? sh[0] : sh[7];
      sh = lsb_i ? sh >> 1 : sh << 1;
   endtask

   initial begin
      miso_o = 1'b0;
      rx_o = 8'h00;
      sh = 8'h00;
   end

   always @(negedge sel_n_i) begin
      sh = tx_i;
      if (!cpha_i) put();
   end

   // released line shows the inverse of its last bit, never a stale copy
   always @(posedge sel_n_i) miso_o = ~miso_o;

   always @(sck_i) begin
      if (!sel_n_i) begin
         if ((sck_i != cpol_i) != cpha_i)
            rx_o = lsb_i ? {mosi_i, rx_o[7:1]} : {rx_o[6:0], mosi_i};
         else
            put();
      end
   end
endmodule

`default_nettype wire

// >>> verification/smsp_port_assertions.sv
// checker: timing and pin-override properties of the serial port
`timescale 1ns/1ns
`default_nettype none

module smsp_port_assertions (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic serial_power_reduction_bit_i,
   input wire logic data_write_i,
   input wire logic select_is_input_i,
   input wire logic select_n_i,
   input wire logic [7:0] serial_control_register_o,
   input wire logic rx_valid_o,
   input wire logic transfer_done_flag_o,
   input wire logic irq_o,
   input wire logic busy_o,
   input wire logic sck_o,
   input wire logic sck_oe_o,
   input wire logic mosi_oe_o,
   input wire logic miso_oe_o
);
   logic [7:0] c;
   logic en;
   assign c = serial_control_register_o;
   assign en = c[6] && !serial_power_reduction_bit_i;

   // the slowest master frame outlasts any delay range, so count it
   logic [10:0] busy_cnt;
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         busy_cnt <= 11'h000;
      end else if (busy_o) begin
         busy_cnt <= busy_cnt + 11'h001;
      end else begin
         busy_cnt <= 11'h000;
      end
   end

   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);

   a_write_starts: assert property (data_write_i && !busy_o && en && c[4]
      && !select_is_input_i |-> ##[1:3] busy_o) else $error("no start");
   a_byte_ends: assert property (busy_o && c[4]
      |-> busy_cnt < 11'h3fc) else $error("transfer never ends");
   a_done_flag: assert property ($fell(busy_o) && c[4]
      |-> ##[0:3] transfer_done_flag_o) else $error("flag not set");
   a_irq_on: assert property ((transfer_done_flag_o && c[7])[*2]
      |-> irq_o) else $error("irq missing");
   a_irq_off: assert property ((!transfer_done_flag_o)[*2]
      |-> !irq_o) else $error("irq without flag");
   a_master_miso: assert property ((en && c[4])[*2]
      |-> !miso_oe_o) else $error("master drives miso");
   a_slave_in: assert property ((en && !c[4])[*2]
      |-> !mosi_oe_o && !sck_oe_o) else $error("slave drives pins");
   a_slave_float: assert property ((en && !c[4] && select_n_i)[*5]
      |-> !miso_oe_o) else $error("miso driven while deselected");
   a_sck_idle: assert property ((en && c[4] && !busy_o && $stable(c))[*4]
      |-> sck_o == c[3]) else $error("sck not at idle level");
   a_fault_slave: assert property ((en && c[4] && select_is_input_i
      && !select_n_i)[*2] |-> ##[0:3] !c[4]) else $error("no mode fault");
   a_rx_kept: assert property ($fell(busy_o) && c[4]
      |-> ##[0:4] rx_valid_o) else $error("byte not kept");

   cover property ($rose(irq_o));
   cover property ($fell(c[4]));
   cover property (rx_valid_o && en && !c[4]);
endmodule

bind smsp_port smsp_port_assertions u_chk (
   .clk_i, .rst_i, .serial_power_reduction_bit_i, .data_write_i,
   .select_is_input_i, .select_n_i, .serial_control_register_o,
   .rx_valid_o, .transfer_done_flag_o, .irq_o, .busy_o, .sck_o,
   .sck_oe_o, .mosi_oe_o, .miso_oe_o
);

`default_nettype wire

// >>> verification/tb_smsp_port.sv
// testbench: master and slave transfers through the serial port
`timescale 1ns/1ns
`default_nettype none

module tb_smsp_port;
   logic clk_i, rst_i, serial_power_reduction_bit_i, ctl_write_i;
   logic double_speed_bit_i, data_write_i, data_read_i, flag_clear_i;
   logic select_is_input_i, select_n_i, m_sck, m_mosi, f_miso;
   logic f_cpol, f_cpha, f_lsb, rx_valid_o, transfer_done_flag_o, irq_o;
   logic busy_o, sck_o, sck_oe_o, mosi_o, mosi_oe_o, miso_o, miso_oe_o;
   logic [7:0] serial_control_register_i, shift_data_register_i, f_tx;
   logic [7:0] f_rx, serial_control_register_o, shift_data_register_o;
   logic [5:0] hv [8];
   int n_mismatch, n_compared;
   // each wire follows whichever party drives it
   wire logic sck_i = sck_oe_o ? sck_o : m_sck;
   wire logic mosi_i = mosi_oe_o ? mosi_o : m_mosi;
   wire logic miso_i = miso_oe_o ? miso_o : f_miso;

   smsp_port uut (
      .clk_i, .rst_i, .serial_power_reduction_bit_i, .ctl_write_i,
      .serial_control_register_i, .double_speed_bit_i, .data_write_i,
      .shift_data_register_i, .data_read_i, .flag_clear_i,
      .select_is_input_i, .miso_user_oe_i(1'b1), .mosi_user_oe_i(1'b1),
      .sck_user_oe_i(1'b1), .sck_i, .mosi_i, .miso_i, .select_n_i,
      .serial_control_register_o, .shift_data_register_o, .rx_valid_o,
      .transfer_done_flag_o, .irq_o, .busy_o, .sck_o, .sck_oe_o,
      .mosi_o, .mosi_oe_o, .miso_o, .miso_oe_o
   );
   smsp_far_slave far (
      .sck_i, .sel_n_i(select_n_i), .mosi_i, .cpol_i(f_cpol),
      .cpha_i(f_cpha), .lsb_i(f_lsb), .tx_i(f_tx), .miso_o(f_miso),
      .rx_o(f_rx)
   );

   // ---------------------------------------------------------
   // helpers
   // ---------------------------------------------------------
   task automatic chk(input logic [7:0] s, input logic [7:0] e);
      n_compared++;
      if (s !== e) begin
         n_mismatch++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   task automatic chk1(input logic s, input logic e);
      chk({7'h00, s}, {7'h00, e});
   endtask
   // k: 0 control, 1 data write, 2 read, 3 flag clear
   task automatic go(input int k, input logic [7:0] v);
      @(negedge clk_i);
      {flag_clear_i, data_read_i, data_write_i, ctl_write_i} = 4'(1 << k);
      serial_control_register_i = v;
      shift_data_register_i = v;
      @(negedge clk_i);
      {flag_clear_i, data_read_i, data_write_i, ctl_write_i} = 4'h0;
   endtask
   task automatic wait_done();
      int n;
      n = 0;
      while (transfer_done_flag_o !== 1'b1 && n < 1200) begin
         @(negedge clk_i);
         n++;
      end
      chk1(transfer_done_flag_o, 1'b1);
      repeat (2) @(negedge clk_i);
   endtask
   task automatic rd(input logic [7:0] e);
      chk1(rx_valid_o, 1'b1);
      chk(shift_data_register_o, e);
      go(2, 8'h00);
      repeat (2) @(negedge clk_i);
   endtask
   task automatic xfer(input logic [7:0] c, input logic [7:0] tx,
                       input logic [7:0] fb);
      {f_lsb, f_cpol, f_cpha} = {c[5], c[3], c[2]};
      f_tx = fb;
      go(0, c);
      repeat (4) @(negedge clk_i);
      select_n_i = 1'b0;
      go(1, tx);
      go(1, ~tx);
      wait_done();
      chk(f_rx, tx);
      chk1(irq_o, c[7]);
      go(3, 8'h00);
      select_n_i = 1'b1;
   endtask
   task automatic sb(input logic [7:0] d, output logic [7:0] q);
      for (int k = 7; k >= 0; k--) begin
         m_mosi = d[k];
         repeat (6) @(negedge clk_i);
         m_sck = 1'b1;
         q[k] = miso_i;
         repeat (6) @(negedge clk_i);
         m_sck = 1'b0;
      end
      repeat (6) @(negedge clk_i);
   endtask

   // ---------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------
   task automatic t_reset();
      chk(serial_control_register_o, smsp_pkg::CTL_RESET);
      chk1(transfer_done_flag_o, 1'b0);
      chk1(busy_o, 1'b0);
   endtask
   task automatic t_power();
      serial_power_reduction_bit_i = 1'b1;
      go(0, 8'h50);
      go(1, 8'h33);
      repeat (4) @(negedge clk_i);
      chk1(busy_o, 1'b0);
      serial_power_reduction_bit_i = 1'b0;
   endtask
   task automatic t_master();
      for (int i = 0; i < 8; i++) begin
         xfer({i[0] ^ i[1], 1'b1, i[0], 1'b1, i[2], i[1], 2'b01},
              8'h1d + 8'(i), 8'hc4 ^ 8'(i * 17));
         rd(8'hc4 ^ 8'(i * 17));
      end
      // third unread byte overruns the two-entry buffer
      xfer(8'h51, 8'ha1, 8'h17);
      xfer(8'h51, 8'ha2, 8'h28);
      xfer(8'h51, 8'ha3, 8'h39);
      rd(8'h17);
      rd(8'h28);
      chk1(rx_valid_o, 1'b0);
   endtask
   task automatic t_rate();
      time t;
      for (int i = 0; i < 8; i++) begin
         double_speed_bit_i = i[2];
         go(0, {6'h14, i[1:0]});
         select_n_i = 1'b0;
         go(1, 8'h55);
         @(posedge sck_o);
         t = $time;
         @(posedge sck_o);
         chk(8'(($time - t) / 8), 8'(2 * hv[i]));
         wait_done();
         go(3, 8'h00);
         select_n_i = 1'b1;
      end
      // only the first two bytes fit; the rest were dropped
      go(2, 8'h00);
      go(2, 8'h00);
   endtask
   task automatic t_fault();
      go(0, 8'h50);
      select_is_input_i = 1'b1;
      select_n_i = 1'b0;
      repeat (8) @(negedge clk_i);
      chk(serial_control_register_o, 8'h40);
      chk1(transfer_done_flag_o, 1'b1);
      go(3, 8'h00);
      select_n_i = 1'b1;
      select_is_input_i = 1'b0;
   endtask
   task automatic t_slave();
      logic [7:0] q;
      go(0, 8'hc0);
      go(1, 8'h4b);
      repeat (2) begin
         m_sck = 1'b1;
         repeat (6) @(negedge clk_i);
         m_sck = 1'b0;
         repeat (6) @(negedge clk_i);
      end
      chk1(miso_oe_o, 1'b0);
      select_n_i = 1'b0;
      repeat (6) @(negedge clk_i);
      sb(8'hd2, q);
      chk(q, 8'h4b);
      wait_done();
      chk1(irq_o, 1'b1);
      go(3, 8'h00);
      go(1, 8'h87);
      sb(8'h2e, q);
      chk(q, 8'h87);
      wait_done();
      select_n_i = 1'b1;
      rd(8'hd2);
      rd(8'h2e);
   endtask

   task automatic conclude();
      $display("compared %0d mismatches %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   initial begin
      clk_i = 1'b0;
      forever #4 clk_i = ~clk_i;
   end
   initial begin
      repeat (20000) @(posedge clk_i);
      n_mismatch++;
      conclude();
   end
   initial begin
      {serial_power_reduction_bit_i, ctl_write_i, data_write_i} = 3'h0;
      {data_read_i, flag_clear_i, select_is_input_i} = 3'h0;
      {double_speed_bit_i, m_sck, m_mosi, f_cpol, f_cpha, f_lsb} = 6'h00;
      {serial_control_register_i, shift_data_register_i, f_tx} = 24'h0;
      select_n_i = 1'b1;
      n_mismatch = 0;
      n_compared = 0;
      hv = '{smsp_pkg::HALF_DIV4, smsp_pkg::HALF_DIV16, smsp_pkg::HALF_DIV64,
             smsp_pkg::HALF_DIV128, smsp_pkg::HALF_DIV2, smsp_pkg::HALF_DIV8,
             smsp_pkg::HALF_DIV32, smsp_pkg::HALF_DIV64};
      rst_i = 1'b1;
      repeat (6) @(negedge clk_i);
      rst_i = 1'b0;
      t_reset();
      t_power();
      t_master();
      t_rate();
      t_fault();
      t_slave();
      conclude();
   end
endmodule

`default_nettype wire
